//--- common/hms_pkg.sv
package hms_pkg;
    typedef logic [6:0] hms_idx_t;
    typedef enum logic [1:0] {SCAN_IDLE, SCAN_CONVERT, SCAN_REST} hms_scan_state_t;

    localparam int NUM_CH = 8;
    localparam int CODE_W = 8;

    // channel numbers in scan order
    localparam logic [2:0] CH_REMOTE = 3'h0;
    localparam logic [2:0] CH_LOCAL = 3'h1;
    localparam logic [2:0] CH_LAST = 3'h7;

    // register indexes; the bus byte address is four times the index
    localparam hms_idx_t IDX_CONFIG = 7'h40;
    localparam hms_idx_t IDX_STATUS1 = 7'h41;
    localparam hms_idx_t IDX_STATUS2 = 7'h42;
    localparam hms_idx_t IDX_VID = 7'h47;
    localparam hms_idx_t IDX_VOLTAGE_ID_BIT_FOUR = 7'h49;
    localparam hms_idx_t IDX_SLAVE_ADDR = 7'h4a;
    // per channel: remote, local, own supply, 12 V, 5 V, 3.3 V, 2.5 V, core supply
    localparam hms_idx_t READ_IDX [NUM_CH] = '{7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27};
    localparam hms_idx_t LIM_HI_IDX [NUM_CH] = '{7'h37, 7'h39, 7'h35, 7'h33, 7'h31, 7'h2f, 7'h2b, 7'h2d};
    localparam hms_idx_t LIM_LO_IDX [NUM_CH] = '{7'h38, 7'h3a, 7'h36, 7'h34, 7'h32, 7'h30, 7'h2c, 7'h2e};
    // where each channel's error flag sits: status register 2 if set, and the bit
    localparam logic STATUS_IN_SR2 [NUM_CH] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    localparam int STATUS_BIT [NUM_CH] = '{5, 4, 1, 0, 3, 2, 0, 1};
    localparam int SR2_DIODE_BIT = 6;

    localparam int CFG_START_BIT = 0;
    localparam int CFG_RESET_BIT = 4;
    localparam int CFG_PIN11_SEL_BIT = 5;
    localparam int CFG_INIT_BIT = 7;
    localparam int VID_RESET_EN_BIT = 7;
    localparam logic [7:0] CONFIG_RESET = 8'h08;
    localparam logic [7:0] CONFIG_WR_MASK = 8'h31;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] LIMIT_RESET = 8'h00;
    localparam logic [6:0] VOLTAGE_ID_BIT_FOUR_FIXED = 7'h40;
    localparam logic [5:0] SLAVE_ADDR_UPPER = 6'h16;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    localparam int CLK_HZ = 50_000_000;
    localparam int SCAN_PERIOD_MS = 1000;
    localparam int SCAN_PERIOD_CYCLES = (CLK_HZ / 1000) * SCAN_PERIOD_MS;
endpackage

//--- rtl/hms_limit_cmp.sv
`timescale 1ns/1ns
module hms_limit_cmp #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] code,
    input wire logic [WIDTH-1:0] limHigh,
    input wire logic [WIDTH-1:0] limLow,
    input wire logic isSigned,
    output logic outOfRange
);
    // equal to a limit is still inside
    wire aboveSigned = $signed(code) > $signed(limHigh);
    wire belowSigned = $signed(code) < $signed(limLow);
    wire aboveUnsigned = code > limHigh;
    wire belowUnsigned = code < limLow;

    assign outOfRange = isSigned ? (aboveSigned | belowSigned) : (aboveUnsigned | belowUnsigned);
endmodule

//--- rtl/hms_scan_seq.sv
`timescale 1ns/1ns
module hms_scan_seq #(
    parameter int PERIOD_CYCLES = hms_pkg::SCAN_PERIOD_CYCLES,
    parameter int CODE_W = hms_pkg::CODE_W
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic run,
    output logic adcRequest,
    output logic [2:0] adcChannel,
    input wire logic adcValid,
    input wire logic [CODE_W-1:0] adcCode,
    input wire logic adcDiodeFault,
    output logic storeValid,
    output logic [2:0] storeChannel,
    output logic [CODE_W-1:0] storeCode,
    output logic storeDiodeFault,
    output logic scanActive
);
    localparam int TW = $clog2(PERIOD_CYCLES + 1);
    localparam logic [TW-1:0] TIMER_LAST = TW'(PERIOD_CYCLES - 1);

    hms_pkg::hms_scan_state_t state;
    hms_pkg::hms_scan_state_t next_state;
    logic [TW-1:0] timer;

    wire timerDone = timer == TIMER_LAST;
    wire lastCh = adcChannel == hms_pkg::CH_LAST;
    wire resultIn = (state == hms_pkg::SCAN_CONVERT) & adcValid;

    assign adcRequest = state == hms_pkg::SCAN_CONVERT;
    assign scanActive = state != hms_pkg::SCAN_IDLE;

    always_comb begin
        next_state = state;
        unique case (state)
            hms_pkg::SCAN_IDLE: if (run) next_state = hms_pkg::SCAN_CONVERT;
            hms_pkg::SCAN_CONVERT: if (resultIn && lastCh) next_state = hms_pkg::SCAN_REST;
            hms_pkg::SCAN_REST: if (timerDone) next_state = hms_pkg::SCAN_CONVERT;
        endcase
        if (!run) begin
            next_state = hms_pkg::SCAN_IDLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= hms_pkg::SCAN_IDLE;
            timer <= '0;
            adcChannel <= hms_pkg::CH_REMOTE;
            storeValid <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            storeValid <= resultIn;
            // a pass restarts the period timer so passes repeat once per period
            if (next_state == hms_pkg::SCAN_IDLE || (state != hms_pkg::SCAN_CONVERT && next_state == hms_pkg::SCAN_CONVERT)) begin
                timer <= '0;
            end else if (!timerDone) begin
                timer <= timer + 1'b1;
            end
            if (next_state != hms_pkg::SCAN_CONVERT) begin
                adcChannel <= hms_pkg::CH_REMOTE;
            end else if (resultIn) begin
                adcChannel <= adcChannel + 1'b1;
            end
        end
    end

    // data side needs no reset; storeValid qualifies it
    always_ff @(posedge ref_clk) begin
        if (ce && resultIn) begin
            storeChannel <= adcChannel;
            storeCode <= adcCode;
            storeDiodeFault <= adcDiodeFault;
        end
    end
endmodule

//--- rtl/hms_monitor.sv
`timescale 1ns/1ns
// Behaviour
// - slave address is fixed upper six bits plus the latched strap level.
// - strap level is caught once after power-up; later pin use leaves it alone.
// - every power-up returns the shared strap pin to address sensing input.
// - power-up loads every defined default; reading registers stay undefined.
// - after power-up the converter is off and no scan runs.
// - power-up clears every limit register to zero.
// - writing one to configuration bit 7 starts a self-clearing software reset.
// - software reset acts like power-up but keeps readings, limits, the latched strap level and resetEnable.
// - start bit set runs continuous scans repeating about once per second.
// - channels convert in order remote, local, own, 12, 5, 3.3, 2.5, core.
// - each result is stored, compared with its limits, and updates its flag.
// - readings and status read at any time, also during a scan.
// - start bit cleared halts scanning and returns to standby.
// - temperatures and their limits are 8-bit two's complement, one degree steps.
// - voltage codes are unsigned, nominal input reads 192.
// - voltage codes saturate at zero and at full scale.
// - the 12 V and fifth voltage-ID shared pin defaults to 12 V input.
// - the device is only a bus slave; the master starts every access.
// - flag is one when the latest stored reading was outside limits, else zero, until a software reset clears it.
// - software reset restores configuration and both status register defaults; a result stored in the same cycle still updates its flag.
module hms_monitor #(
    parameter int SCAN_PERIOD_CYCLES = hms_pkg::SCAN_PERIOD_CYCLES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [8:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    input wire logic addressStrapPin,
    input wire logic [3:0] voltageIdPins,
    input wire logic voltageIdBitFour,
    output logic strapPinIsAddressInput,
    output logic twelveVoltPinIsVoltageId,
    output logic [6:0] slaveAddress,
    output logic monitorRunning,
    output logic adcRequest,
    output logic [2:0] adcChannel,
    input wire logic adcValid,
    input wire logic [7:0] adcCode,
    input wire logic adcDiodeFault
);
    localparam int NCH = hms_pkg::NUM_CH;

    // ---------------- bus slave ----------------
    logic busAck;
    logic [7:0] readByte;
    logic [7:0] readData;

    wire busReq = avsRead | avsWrite;
    wire [6:0] wordIdx = avsAddress[8:2];
    // the write takes effect on the edge where the master sees waitrequest low
    wire wrFire = avsWrite & busAck & avsByteEnable[0];
    wire rdLatch = avsRead & ~busAck;

    assign avsWaitRequest = busReq & ~busAck;
    assign avsReadData = {24'h000000, readData};

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busAck <= 1'b0;
        end else if (ce) begin
            busAck <= busReq & ~busAck;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            readData <= 8'h00;
        end else if (ce && rdLatch) begin
            readData <= readByte;
        end
    end

    // ---------------- pins from outside the clock domain ----------------
    logic strapMeta;
    logic strapSync;
    logic [4:0] vidMeta;
    logic [4:0] vidSync;

    always_ff @(posedge ref_clk) begin
        if (ce) begin
            strapMeta <= addressStrapPin;
            strapSync <= strapMeta;
            vidMeta <= {voltageIdBitFour, voltageIdPins};
            vidSync <= vidMeta;
        end
    end

    // ---------------- address strap capture ----------------
    logic [1:0] strapSettle;
    logic strapCaptured;
    logic strapLevel;

    wire strapTake = ~strapCaptured & (strapSettle == hms_pkg::STRAP_SETTLE);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            strapSettle <= 2'h0;
            strapCaptured <= 1'b0;
            strapLevel <= 1'b0;
        end else if (ce) begin
            if (!strapCaptured && !strapTake) begin
                strapSettle <= strapSettle + 2'h1;
            end
            // caught once after release; software reset does not re-arm it
            if (strapTake) begin
                strapLevel <= strapSync;
                strapCaptured <= 1'b1;
            end
        end
    end

    assign slaveAddress = {hms_pkg::SLAVE_ADDR_UPPER, strapLevel};

    // ---------------- configuration and identity registers ----------------
    logic [7:0] cfgReg;
    logic resetEnable;

    wire wrConfig = wrFire & (wordIdx == hms_pkg::IDX_CONFIG);
    wire wrVid = wrFire & (wordIdx == hms_pkg::IDX_VID);
    wire swInit = wrConfig & avsWriteData[hms_pkg::CFG_INIT_BIT];
    wire runRequest = cfgReg[hms_pkg::CFG_START_BIT];
    wire pin11Vid = cfgReg[hms_pkg::CFG_PIN11_SEL_BIT];
    wire [7:0] vidByte = {resetEnable, 3'h0, vidSync[3:0]};
    wire [7:0] vid4Byte = {hms_pkg::VOLTAGE_ID_BIT_FOUR_FIXED, pin11Vid & vidSync[4]};

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfgReg <= hms_pkg::CONFIG_RESET;
        end else if (ce && wrConfig) begin
            if (swInit) begin
                cfgReg <= hms_pkg::CONFIG_RESET;
            end else begin
                // reserved bits keep their fixed values
                cfgReg <= (avsWriteData[7:0] & hms_pkg::CONFIG_WR_MASK) | (hms_pkg::CONFIG_RESET & ~hms_pkg::CONFIG_WR_MASK);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            resetEnable <= 1'b0;
        end else if (ce && wrVid) begin
            resetEnable <= avsWriteData[hms_pkg::VID_RESET_EN_BIT];
        end
    end

    assign strapPinIsAddressInput = ~resetEnable;
    assign twelveVoltPinIsVoltageId = pin11Vid;

    // ---------------- scan sequencer and limit compare ----------------
    logic storeValid;
    logic [2:0] storeChannel;
    logic [7:0] storeCode;
    logic storeDiodeFault;
    logic outOfRange;
    logic [7:0] curHigh;
    logic [7:0] curLow;

    // software reset also stops the scan, since it clears the start bit
    hms_scan_seq #(
        .PERIOD_CYCLES(SCAN_PERIOD_CYCLES),
        .CODE_W(hms_pkg::CODE_W)
    ) u_seq (
        .ref_clk(ref_clk),
        .srst(srst),
        .ce(ce),
        .run(runRequest),
        .adcRequest(adcRequest),
        .adcChannel(adcChannel),
        .adcValid(adcValid),
        .adcCode(adcCode),
        .adcDiodeFault(adcDiodeFault),
        .storeValid(storeValid),
        .storeChannel(storeChannel),
        .storeCode(storeCode),
        .storeDiodeFault(storeDiodeFault),
        .scanActive(monitorRunning)
    );

    // temperature channels are two's complement, voltages straight binary
    wire curSigned = (storeChannel == hms_pkg::CH_REMOTE) | (storeChannel == hms_pkg::CH_LOCAL);

    hms_limit_cmp #(
        .WIDTH(hms_pkg::CODE_W)
    ) u_cmp (
        .code(storeCode),
        .limHigh(curHigh),
        .limLow(curLow),
        .isSigned(curSigned),
        .outOfRange(outOfRange)
    );

    // ---------------- per-channel readings, limits and flags ----------------
    logic [7:0] reading [NCH];
    logic [7:0] limHigh [NCH];
    logic [7:0] limLow [NCH];
    logic [NCH-1:0] errFlag;
    logic diodeFault;

    wire [7:0] rdAcc [NCH+1];
    wire [7:0] hiAcc [NCH+1];
    wire [7:0] loAcc [NCH+1];
    wire [7:0] sr1Acc [NCH+1];
    wire [7:0] sr2Acc [NCH+1];

    assign rdAcc[0] = 8'h00;
    assign hiAcc[0] = 8'h00;
    assign loAcc[0] = 8'h00;
    assign sr1Acc[0] = 8'h00;
    assign sr2Acc[0] = 8'h00;

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_ch
            wire selRead = wordIdx == hms_pkg::READ_IDX[ch];
            wire selHigh = wordIdx == hms_pkg::LIM_HI_IDX[ch];
            wire selLow = wordIdx == hms_pkg::LIM_LO_IDX[ch];
            wire isStore = storeValid & (storeChannel == 3'(ch));
            wire [7:0] flagPos = 8'h01 << hms_pkg::STATUS_BIT[ch];

            // converter codes arrive already saturated to 0..255
            always_ff @(posedge ref_clk) begin
                if (ce && isStore) begin
                    reading[ch] <= storeCode;
                end
            end

            // limits survive software reset
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    limHigh[ch] <= hms_pkg::LIMIT_RESET;
                    limLow[ch] <= hms_pkg::LIMIT_RESET;
                end else if (ce) begin
                    if (wrFire && selHigh) begin
                        limHigh[ch] <= avsWriteData[7:0];
                    end
                    if (wrFire && selLow) begin
                        limLow[ch] <= avsWriteData[7:0];
                    end
                end
            end

            // a result landing with a software reset wins over the clear
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    errFlag[ch] <= 1'b0;
                end else if (ce) begin
                    if (isStore) begin
                        errFlag[ch] <= outOfRange;
                    end else if (swInit) begin
                        errFlag[ch] <= 1'b0;
                    end
                end
            end

            assign rdAcc[ch+1] = rdAcc[ch] | ({8{selRead}} & reading[ch]) | ({8{selHigh}} & limHigh[ch])
                | ({8{selLow}} & limLow[ch]);
            assign hiAcc[ch+1] = hiAcc[ch] | ({8{storeChannel == 3'(ch)}} & limHigh[ch]);
            assign loAcc[ch+1] = loAcc[ch] | ({8{storeChannel == 3'(ch)}} & limLow[ch]);
            assign sr1Acc[ch+1] = sr1Acc[ch] | ((errFlag[ch] & ~hms_pkg::STATUS_IN_SR2[ch]) ? flagPos : 8'h00);
            assign sr2Acc[ch+1] = sr2Acc[ch] | ((errFlag[ch] & hms_pkg::STATUS_IN_SR2[ch]) ? flagPos : 8'h00);
        end
    endgenerate

    assign curHigh = hiAcc[NCH];
    assign curLow = loAcc[NCH];

    wire diodeStore = storeValid & (storeChannel == hms_pkg::CH_REMOTE);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            diodeFault <= 1'b0;
        end else if (ce) begin
            if (diodeStore) begin
                diodeFault <= storeDiodeFault;
            end else if (swInit) begin
                diodeFault <= 1'b0;
            end
        end
    end

    wire [7:0] status1 = hms_pkg::STATUS_RESET | sr1Acc[NCH];
    wire [7:0] status2 = hms_pkg::STATUS_RESET | sr2Acc[NCH] | (diodeFault ? 8'h40 : 8'h00);

    // ---------------- read selection ----------------
    wire selConfig = wordIdx == hms_pkg::IDX_CONFIG;
    wire selSr1 = wordIdx == hms_pkg::IDX_STATUS1;
    wire selSr2 = wordIdx == hms_pkg::IDX_STATUS2;
    wire selVid = wordIdx == hms_pkg::IDX_VID;
    wire selVid4 = wordIdx == hms_pkg::IDX_VOLTAGE_ID_BIT_FOUR;
    wire selAddr = wordIdx == hms_pkg::IDX_SLAVE_ADDR;

    // unmapped indexes read as zero; the init bit always reads zero
    assign readByte = rdAcc[NCH]
        | ({8{selConfig}} & cfgReg)
        | ({8{selSr1}} & status1)
        | ({8{selSr2}} & status2)
        | ({8{selVid}} & vidByte)
        | ({8{selVid4}} & vid4Byte)
        | ({8{selAddr}} & {1'b0, slaveAddress});
endmodule

//--- tb/hms_adc_model.sv
`timescale 1ns/1ns
module hms_adc_model (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [3:0] delay,
    input wire logic adcRequest,
    input wire logic [2:0] adcChannel,
    output logic adcValid,
    output logic [7:0] adcCode,
    output logic adcDiodeFault
);
    // codes come already saturated, as the analog front end delivers them
    localparam logic [7:0] CODES [8] = '{8'hf0, 8'h19, 8'hc0, 8'h10, 8'hc0, 8'hff, 8'h00, 8'h80};
    logic [3:0] waitCnt;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            waitCnt <= 4'h0;
            adcValid <= 1'b0;
            adcCode <= 8'h00;
            adcDiodeFault <= 1'b0;
        end else if (adcRequest && !adcValid && waitCnt >= delay) begin
            adcValid <= 1'b1;
            adcCode <= CODES[adcChannel];
            adcDiodeFault <= (adcChannel == 3'h0);
            waitCnt <= 4'h0;
        end else begin
            // outside a result the lines churn so a stale value is never taken for data
            adcValid <= 1'b0;
            adcCode <= ~adcCode;
            adcDiodeFault <= ~adcDiodeFault;
            waitCnt <= adcRequest ? waitCnt + 4'h1 : 4'h0;
        end
    end
endmodule

//--- tb/hms_check_monitor.sv
`timescale 1ns/1ns
module hms_check_monitor (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic avsWaitRequest,
    input wire logic [31:0] avsReadData,
    input wire logic strapPinIsAddressInput,
    input wire logic twelveVoltPinIsVoltageId,
    input wire logic [6:0] slaveAddress,
    input wire logic monitorRunning,
    input wire logic adcRequest,
    input wire logic [2:0] adcChannel,
    input wire logic adcValid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic [2:0] sinceRst;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sinceRst <= 3'h0;
        end else if (ce && sinceRst != 3'h7) begin
            sinceRst <= sinceRst + 3'h1;
        end
    end
    wait_state_a: assert property ((avsRead || avsWrite) && avsWaitRequest && ce |=> !avsWaitRequest)
        else $error("bus request not answered after one wait state");
    idle_wait_a: assert property (!(avsRead || avsWrite) |-> !avsWaitRequest)
        else $error("waitrequest high with no request");
    read_lanes_a: assert property (avsReadData[31:8] == 24'h0)
        else $error("read data upper lanes not zero");
    rdata_hold_a: assert property (!(avsRead && avsWaitRequest && ce) |=> $stable(avsReadData))
        else $error("read data changed without a read");
    addr_fixed_a: assert property (slaveAddress[6:1] == hms_pkg::SLAVE_ADDR_UPPER)
        else $error("slave address upper bits wrong");
    strap_hold_a: assert property (sinceRst == 3'h7 |-> $stable(slaveAddress))
        else $error("slave address changed after capture");
    pin_roles_a: assert property ($fell(srst) |-> strapPinIsAddressInput && !twelveVoltPinIsVoltageId && !monitorRunning)
        else $error("pin roles or standby wrong after reset");
    standby_a: assert property (!monitorRunning |-> !adcRequest)
        else $error("conversion requested in standby");
    req_hold_a: assert property (adcRequest && !adcValid && ce |=> !monitorRunning || (adcRequest && $stable(adcChannel)))
        else $error("converter request dropped or channel moved early");
    chan_step_a: assert property (adcRequest && adcValid && ce && adcChannel != 3'h7
        |=> !monitorRunning || (adcRequest && adcChannel == $past(adcChannel) + 3'h1))
        else $error("channel did not advance in order");
    first_chan_a: assert property ($rose(monitorRunning) |-> adcRequest && adcChannel == hms_pkg::CH_REMOTE)
        else $error("scan did not start at the remote channel");
    pass_start_c: cover property ($rose(monitorRunning));
    last_chan_c: cover property (adcRequest && adcValid && adcChannel == 3'h7);
    busy_read_c: cover property (monitorRunning && avsRead && !avsWaitRequest);
endmodule
bind hms_monitor hms_check_monitor i_check (.ref_clk(ref_clk), .srst(srst), .ce(ce), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWaitRequest(avsWaitRequest), .avsReadData(avsReadData),
    .strapPinIsAddressInput(strapPinIsAddressInput), .twelveVoltPinIsVoltageId(twelveVoltPinIsVoltageId),
    .slaveAddress(slaveAddress), .monitorRunning(monitorRunning), .adcRequest(adcRequest),
    .adcChannel(adcChannel), .adcValid(adcValid));

//--- tb/hms_monitor_test.sv
`timescale 1ns/1ns
module hms_monitor_test;
    localparam int PERIOD = 200;
    localparam int LIMIT = 5000;
    localparam logic [7:0] HI [8] = '{8'h19, 8'h19, 8'hbf, 8'hff, 8'hc0, 8'hfe, 8'hff, 8'hff};
    localparam logic [7:0] LO [8] = '{8'he7, 8'h00, 8'h00, 8'h20, 8'hc0, 8'h00, 8'h00, 8'h81};
    localparam logic [7:0] CODES [8] = '{8'hf0, 8'h19, 8'hc0, 8'h10, 8'hc0, 8'hff, 8'h00, 8'h80};
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic [8:0] avsAddress = 9'h000;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0;
    logic [3:0] avsByteEnable = 4'hf;
    logic addressStrapPin = 1'b1;
    logic [3:0] voltageIdPins = 4'ha;
    logic voltageIdBitFour = 1'b1;
    logic [3:0] adcDelay = 4'h0;
    logic [31:0] avsReadData;
    logic avsWaitRequest, strapPinIsAddressInput, twelveVoltPinIsVoltageId, monitorRunning;
    logic adcRequest, adcValid, adcDiodeFault, reqPrev = 1'b0;
    logic [6:0] slaveAddress;
    logic [2:0] adcChannel;
    logic [7:0] adcCode, rd;
    logic [2:0] chLog [$];
    int passStart [$];
    int miscompares = 0, n_compared = 0, cycles = 0;

    hms_monitor #(.SCAN_PERIOD_CYCLES(PERIOD)) i_dut (.ref_clk(ref_clk), .srst(srst), .ce(ce),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
        .avsByteEnable(avsByteEnable), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .addressStrapPin(addressStrapPin), .voltageIdPins(voltageIdPins), .voltageIdBitFour(voltageIdBitFour),
        .strapPinIsAddressInput(strapPinIsAddressInput), .twelveVoltPinIsVoltageId(twelveVoltPinIsVoltageId),
        .slaveAddress(slaveAddress), .monitorRunning(monitorRunning), .adcRequest(adcRequest),
        .adcChannel(adcChannel), .adcValid(adcValid), .adcCode(adcCode), .adcDiodeFault(adcDiodeFault));
    hms_adc_model i_adc (.ref_clk(ref_clk), .srst(srst), .delay(adcDelay), .adcRequest(adcRequest),
        .adcChannel(adcChannel), .adcValid(adcValid), .adcCode(adcCode), .adcDiodeFault(adcDiodeFault));

    initial forever #10 ref_clk = ~ref_clk;

    task automatic end_sim();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (adcRequest === 1'b1 && adcValid === 1'b1) chLog.push_back(adcChannel);
        if (adcRequest === 1'b1 && reqPrev !== 1'b1 && adcChannel === 3'h0) passStart.push_back(cycles);
        reqPrev <= adcRequest;
        if (cycles == LIMIT) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic checkBit(input string what, input logic exp, input logic got);
        check8(what, {7'h0, exp}, {7'h0, got});
    endtask
    // one request, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] wd);
        @(posedge ref_clk);
        avsAddress <= {idx, 2'b00};
        avsWriteData <= {24'h0, wd};
        avsWrite <= wr;
        avsRead <= !wr;
        do @(posedge ref_clk); while (avsWaitRequest !== 1'b0);
        rd = avsReadData[7:0];
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask
    task automatic wr8(input logic [6:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd);
    endtask
    task automatic rd8(input string what, input logic [6:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check8(what, exp, rd);
    endtask

    task automatic t_defaults();
        for (int i = 0; i < 8; i++) begin
            rd8("limit hi", hms_pkg::LIM_HI_IDX[i], 8'h00);
            rd8("limit lo", hms_pkg::LIM_LO_IDX[i], 8'h00);
        end
        rd8("config", hms_pkg::IDX_CONFIG, 8'h08);
        rd8("status1", hms_pkg::IDX_STATUS1, 8'h00);
        rd8("status2", hms_pkg::IDX_STATUS2, 8'h00);
        rd8("vid", hms_pkg::IDX_VID, 8'h0a);
        rd8("voltage_id_bit_four", hms_pkg::IDX_VOLTAGE_ID_BIT_FOUR, 8'h80);
        rd8("slave addr", hms_pkg::IDX_SLAVE_ADDR, 8'h2d);
        rd8("unmapped", 7'h10, 8'h00);
        checkBit("strap role", 1'b1, strapPinIsAddressInput);
        checkBit("pin11 role", 1'b0, twelveVoltPinIsVoltageId);
        checkBit("running", 1'b0, monitorRunning);
        wr8(hms_pkg::IDX_VID, 8'h80);
        rd8("vid", hms_pkg::IDX_VID, 8'h8a);
        checkBit("strap role", 1'b0, strapPinIsAddressInput);
        addressStrapPin <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check8("slave addr pins", 8'h2d, {1'b0, slaveAddress});
    endtask

    task automatic t_scan();
        int d;
        for (int i = 0; i < 8; i++) begin
            wr8(hms_pkg::LIM_HI_IDX[i], HI[i]);
            wr8(hms_pkg::LIM_LO_IDX[i], LO[i]);
        end
        adcDelay <= 4'h3;
        wr8(hms_pkg::IDX_CONFIG, 8'h01);
        while (chLog.size() < 8) @(posedge ref_clk);
        repeat (4) @(posedge ref_clk);
        checkBit("running", 1'b1, monitorRunning);
        for (int i = 0; i < 8; i++) rd8("reading", hms_pkg::READ_IDX[i], CODES[i]);
        // signed temps, unsigned volts, equal-to-limit inside, diode fault set
        rd8("status1", hms_pkg::IDX_STATUS1, 8'h06);
        rd8("status2", hms_pkg::IDX_STATUS2, 8'h43);
        while (chLog.size() < 16) @(posedge ref_clk);
        for (int i = 0; i < 16; i++) check8("channel", 8'(i % 8), {5'h0, chLog[i]});
        d = passStart[1] - passStart[0];
        checkBit("period", 1'b1, d >= PERIOD - 1 && d <= PERIOD + 1);
    endtask

    task automatic t_stop();
        int n;
        wr8(hms_pkg::IDX_CONFIG, 8'h00);
        repeat (2) @(posedge ref_clk);
        checkBit("running", 1'b0, monitorRunning);
        checkBit("request", 1'b0, adcRequest);
        n = chLog.size();
        repeat (300) @(posedge ref_clk);
        check8("conversions", 8'(n), 8'(chLog.size()));
    endtask

    task automatic t_init();
        adcDelay <= 4'h0;
        wr8(hms_pkg::IDX_CONFIG, 8'h21);
        repeat (2) @(posedge ref_clk);
        checkBit("pin11 role", 1'b1, twelveVoltPinIsVoltageId);
        rd8("voltage_id_bit_four", hms_pkg::IDX_VOLTAGE_ID_BIT_FOUR, 8'h81);
        wr8(hms_pkg::IDX_CONFIG, 8'h80);
        repeat (2) @(posedge ref_clk);
        checkBit("running", 1'b0, monitorRunning);
        checkBit("pin11 role", 1'b0, twelveVoltPinIsVoltageId);
        // a second init once idle, so no late result can refill a flag
        repeat (10) @(posedge ref_clk);
        wr8(hms_pkg::IDX_CONFIG, 8'h80);
        rd8("config", hms_pkg::IDX_CONFIG, 8'h08);
        rd8("status1", hms_pkg::IDX_STATUS1, 8'h00);
        rd8("status2", hms_pkg::IDX_STATUS2, 8'h00);
        rd8("reading", hms_pkg::READ_IDX[3], CODES[3]);
        rd8("limit", hms_pkg::LIM_LO_IDX[7], LO[7]);
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        t_defaults();
        t_scan();
        t_stop();
        t_init();
        end_sim();
    end
endmodule
